// ---- logic/fpe_array_mem.sv ----
// Flash array storage, 32-bit words with halfword write lanes.
`timescale 1ns/1ps
module fpe_array_mem
  import fpe_pkg::*;
(
  input wire logic clk_sys,
  input wire logic we,
  input wire logic re,
  input wire logic [WAW-1:0] addr,
  input wire logic [1:0] be,
  input wire logic [31:0] wd,
  output logic [31:0] rd_q
);

  logic [31:0] mem [0:N_WORDS-1];

  // The array powers up erased, as a fresh flash would.
  initial begin
    for (int i = 0; i < N_WORDS; i++) begin
      mem[i] = ERASED;
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int l = 0; l < 2; l++) begin
      if (we && be[l]) begin
        mem[addr][l*16 +: 16] <= wd[l*16 +: 16];
      end
    end
    if (re) begin
      rd_q <= mem[addr];
    end
  end

endmodule

// ---- logic/fpe_flash_ctrl.sv ----
// Flash program and erase sequencer with read path and mode straps.
`timescale 1ns/1ps
module fpe_flash_ctrl
  import fpe_pkg::*;
#(
  parameter int unsigned ERASE_CYC = CHIP_ERASE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire fpe_req_t req,
  input wire logic prog_mode,
  input wire logic vpp_high,
  input wire logic boot_strap_pin,
  input wire logic interleave_strap_pin,
  input wire logic reset_sampled_strap_a,
  input wire logic reset_sampled_strap_b,
  output fpe_rsp_t rsp_q,
  output logic busy_q,
  output fpe_mode_t mode_q,
  output logic secure_q,
  output logic [N_BLK-1:0] prot_q
);

  // -------------------------------------------------------------------
  // Mode straps
  // -------------------------------------------------------------------
  // The straps are taken on the first edge after release, which the
  // outside holds stable for one clock around that edge.
  logic rst_q;
  logic rst_d;
  fpe_mode_t mode_d;

  always_comb begin
    rst_d = rst;
    mode_d = mode_q;
    if (rst_q && !rst) begin
      mode_d.interleave = interleave_strap_pin;
      mode_d.boot_rom = !boot_strap_pin;
      mode_d.strap_a = reset_sampled_strap_a;
      mode_d.strap_b = reset_sampled_strap_b;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rst_q <= 1'b1;
      mode_q <= MODE_RST;
    end else begin
      rst_q <= rst_d;
      mode_q <= mode_d;
    end
  end

  // -------------------------------------------------------------------
  // Array and request decode
  // -------------------------------------------------------------------
  logic m_we;
  logic m_re;
  logic [WAW-1:0] m_addr;
  logic [1:0] m_be;
  logic [31:0] m_wd;
  logic [31:0] m_rd;
  logic rd_pend_q;
  logic acc;
  logic wr;
  logic rd;
  logic a1;
  logic a2;
  logic [4:0] rblk;
  logic [4:0] wblk;
  logic [N_BLK-1:0] lockv;

  fpe_array_mem u_mem (
    .clk_sys(clk_sys),
    .we(m_we),
    .re(m_re),
    .addr(m_addr),
    .be(m_be),
    .wd(m_wd),
    .rd_q(m_rd)
  );

  // One request at a time: anything offered while a read is in
  // flight is dropped, which keeps the array port free of conflicts.
  assign acc = req.valid && !rd_pend_q;
  assign wr = acc && req.we;
  assign rd = acc && !req.we;
  assign a1 = req.addr[15:1] == CMD_A1;
  assign a2 = req.addr[15:1] == CMD_A2;
  assign rblk = blk_of(req.addr);
  logic [WAW-1:0] walk_q;
  assign wblk = blk_of({walk_q, 2'h0});
  assign lockv = prot_q & {N_BLK{!vpp_high}};

  // -------------------------------------------------------------------
  // Sequencer
  // -------------------------------------------------------------------
  fpe_state_t st_q;
  fpe_state_t st_d;
  logic [31:0] tmr_q;
  logic [31:0] tmr_d;
  logic [WAW-1:0] walk_d;
  logic ph_q;
  logic ph_d;
  logic [2:0] cyc_q;
  logic [2:0] cyc_d;
  logic [1:0] op_q;
  logic [1:0] op_d;
  logic [N_BLK-1:0] emask_q;
  logic [N_BLK-1:0] emask_d;
  logic [AW-1:0] paddr_q;
  logic [AW-1:0] paddr_d;
  logic [15:0] pdata_q;
  logic [15:0] pdata_d;
  logic fail_q;
  logic fail_d;
  logic sec_d;
  logic [N_BLK-1:0] prot_d;
  logic busy_d;
  logic wsel;

  assign wsel = emask_q[wblk] && !lockv[wblk];

  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q;
    walk_d = walk_q;
    ph_d = ph_q;
    cyc_d = cyc_q;
    op_d = op_q;
    emask_d = emask_q;
    paddr_d = paddr_q;
    pdata_d = pdata_q;
    fail_d = fail_q;
    sec_d = secure_q;
    prot_d = prot_q;
    m_we = 1'b0;
    m_re = 1'b0;
    m_addr = req.addr[18:2];
    m_be = 2'h3;
    m_wd = ERASED;
    case (st_q)
      ST_IDLE: begin
        m_re = rd;
        if (wr && req.wdata == D_RST) begin
          cyc_d = 3'h0;
          fail_d = 1'b0;
        end else if (wr) begin
          cyc_d = 3'h0;
          case (cyc_q)
            3'h0: if (a1 && req.wdata == D_UNL1) cyc_d = 3'h1;
            3'h1: if (a2 && req.wdata == D_UNL2) cyc_d = 3'h2;
            3'h2: begin
              if (a1 && req.wdata == D_PROG) begin
                cyc_d = 3'h3;
                op_d = OP_PROG;
              end else if (a1 && req.wdata == D_SEC) begin
                cyc_d = 3'h3;
                op_d = OP_SEC;
              end else if (a1 && req.wdata == D_PROT) begin
                cyc_d = 3'h3;
                op_d = OP_PROT;
              end else if (a1 && req.wdata == D_ERS) begin
                cyc_d = 3'h4;
              end
            end
            3'h3: begin
              if (op_q == OP_PROT) begin
                prot_d[rblk] = 1'b1;
              end else if (!lockv[rblk]) begin
                paddr_d = req.addr;
                pdata_d = req.wdata;
                fail_d = 1'b0;
                tmr_d = 32'(PROG_CYC - 1);
                st_d = ST_PWAIT;
                if (op_q == OP_SEC) sec_d = 1'b1;
              end
            end
            3'h4: if (a1 && req.wdata == D_UNL1) cyc_d = 3'h5;
            3'h5: if (a2 && req.wdata == D_UNL2) cyc_d = 3'h6;
            3'h6: begin
              fail_d = 1'b0;
              if (a1 && req.wdata == D_CHIP) begin
                emask_d = {N_BLK{1'b1}};
                sec_d = 1'b0;
                tmr_d = 32'(ERASE_CYC - 1);
                st_d = ST_EWAIT;
              end else if (req.wdata == D_BLK) begin
                emask_d[rblk] = 1'b1;
                tmr_d = 32'(MB_WIN_CYC - 1);
                st_d = ST_ECOL;
              end
            end
            default: cyc_d = 3'h0;
          endcase
        end
      end
      ST_ECOL: begin
        // Further block writes extend the multi-block selection window.
        if (wr && req.wdata == D_BLK) begin
          emask_d[rblk] = 1'b1;
          tmr_d = 32'(MB_WIN_CYC - 1);
        end else if (tmr_q == 32'h0) begin
          tmr_d = 32'(ERASE_CYC - 1);
          st_d = ST_EWAIT;
        end else begin
          tmr_d = tmr_q - 32'h1;
        end
      end
      ST_EWAIT: begin
        // No write is looked at here, so an erase cannot be paused.
        if (tmr_q == 32'h0) begin
          walk_d = '0;
          st_d = ST_EWALK;
        end else begin
          tmr_d = tmr_q - 32'h1;
        end
      end
      ST_EWALK: begin
        m_addr = walk_q;
        m_we = wsel;
        walk_d = walk_q + 1'b1;
        if (walk_q == {WAW{1'b1}}) begin
          ph_d = 1'b0;
          st_d = ST_EVER;
        end
      end
      ST_EVER: begin
        m_addr = walk_q;
        if (wsel && !ph_q) begin
          m_re = 1'b1;
          ph_d = 1'b1;
        end else begin
          if (wsel && m_rd != ERASED) fail_d = 1'b1;
          ph_d = 1'b0;
          walk_d = walk_q + 1'b1;
          if (walk_q == {WAW{1'b1}}) begin
            emask_d = '0;
            st_d = ST_IDLE;
          end
        end
      end
      ST_PWAIT: begin
        m_addr = paddr_q[18:2];
        m_be = paddr_q[1] ? 2'h2 : 2'h1;
        m_wd = {pdata_q, pdata_q};
        if (tmr_q == 32'h0) begin
          m_we = 1'b1;
          ph_d = 1'b0;
          st_d = ST_PVER;
        end else begin
          tmr_d = tmr_q - 32'h1;
        end
      end
      ST_PVER: begin
        m_addr = paddr_q[18:2];
        if (!ph_q) begin
          m_re = 1'b1;
          ph_d = 1'b1;
        end else begin
          if ((paddr_q[1] ? m_rd[31:16] : m_rd[15:0]) != pdata_q) begin
            fail_d = 1'b1;
          end
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    busy_d = st_d != ST_IDLE;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= ST_IDLE;
      tmr_q <= 32'h0;
      walk_q <= '0;
      ph_q <= 1'b0;
      cyc_q <= 3'h0;
      op_q <= OP_PROG;
      emask_q <= '0;
      paddr_q <= '0;
      pdata_q <= 16'h0;
      fail_q <= 1'b0;
      secure_q <= 1'b0;
      prot_q <= PROT_RST;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      walk_q <= walk_d;
      ph_q <= ph_d;
      cyc_q <= cyc_d;
      op_q <= op_d;
      emask_q <= emask_d;
      paddr_q <= paddr_d;
      pdata_q <= pdata_d;
      fail_q <= fail_d;
      secure_q <= sec_d;
      prot_q <= prot_d;
      busy_q <= busy_d;
    end
  end

  // -------------------------------------------------------------------
  // Read path
  // -------------------------------------------------------------------
  logic rd_pend_d;
  logic [1:0] rd_cnt_q;
  logic [1:0] rd_cnt_d;
  logic rd_stat_q;
  logic rd_stat_d;
  logic tog_q;
  logic tog_d;
  logic [1:0] lat;
  logic [31:0] stat;
  fpe_rsp_t rsp_d;

  assign lat = mode_q.interleave ? RD_LAT_ILV : RD_LAT_FAST;

  always_comb begin
    stat = 32'h0;
    stat[POLL_BIT] = (st_q == ST_PWAIT || st_q == ST_PVER) ?
                     !pdata_q[7] : 1'b0;
    stat[TOG_BIT] = tog_q;
    stat[FAIL_BIT] = fail_q;
    rd_pend_d = rd_pend_q;
    rd_cnt_d = rd_cnt_q;
    rd_stat_d = rd_stat_q;
    tog_d = tog_q;
    rsp_d = '0;
    if (rd) begin
      rd_pend_d = 1'b1;
      rd_cnt_d = 2'h0;
      rd_stat_d = st_q != ST_IDLE;
    end else if (rd_pend_q) begin
      if (rd_cnt_q == lat) begin
        rd_pend_d = 1'b0;
        rsp_d.valid = 1'b1;
        if (rd_stat_q) begin
          rsp_d.rdata = stat;
          tog_d = !tog_q;
        end else if (secure_q && prog_mode) begin
          rsp_d.rdata = 32'h0;
        end else begin
          rsp_d.rdata = m_rd;
        end
      end else begin
        rd_cnt_d = rd_cnt_q + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_pend_q <= 1'b0;
      rd_cnt_q <= 2'h0;
      rd_stat_q <= 1'b0;
      tog_q <= 1'b0;
      rsp_q <= '0;
    end else begin
      rd_pend_q <= rd_pend_d;
      rd_cnt_q <= rd_cnt_d;
      rd_stat_q <= rd_stat_d;
      tog_q <= tog_d;
      rsp_q <= rsp_d;
    end
  end

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  logic [10:0] pw_cnt_q;

  always_ff @(posedge clk_sys) begin
    if (rst) pw_cnt_q <= 11'h0;
    else if (st_q == ST_PWAIT) pw_cnt_q <= pw_cnt_q + 11'h1;
    else pw_cnt_q <= 11'h0;
  end

  chk_strap_hold: assert property (
    @(posedge clk_sys) disable iff (rst)
    (!rst_q && !$past(rst_q)) |-> $stable(mode_q))
    else $error("Latched straps changed outside reset release.");

  chk_interleave_select_sel: assert property (
    @(posedge clk_sys) disable iff (rst)
    $fell(rst_q) |-> mode_q.interleave == $past(interleave_strap_pin))
    else $error("Interleave select does not follow its strap.");

  chk_boot_sel: assert property (
    @(posedge clk_sys) disable iff (rst)
    $fell(rst_q) |-> mode_q.boot_rom == !$past(boot_strap_pin))
    else $error("Boot ROM select does not follow its strap.");

  chk_read_fast: assert property (
    @(posedge clk_sys) disable iff (rst)
    (rd && !mode_q.interleave) |-> !rsp_q.valid ##1 !rsp_q.valid
    ##1 rsp_q.valid)
    else $error("Single-clock read answer not two cycles later.");

  chk_read_ilv: assert property (
    @(posedge clk_sys) disable iff (rst)
    (rd && mode_q.interleave) |-> ##2 !rsp_q.valid ##1 rsp_q.valid)
    else $error("Interleaved read answer not three cycles later.");

  chk_prog_dwell: assert property (
    @(posedge clk_sys) disable iff (rst)
    ($past(st_q) == ST_PWAIT && st_q != ST_PWAIT)
    |-> pw_cnt_q == 11'(PROG_CYC))
    else $error("Program pulse length is wrong.");

  chk_prog_start: assert property (
    @(posedge clk_sys) disable iff (rst)
    (wr && st_q == ST_IDLE && cyc_q == 3'h3 && op_q != OP_PROT &&
     req.wdata != D_RST && !lockv[rblk]) |=> st_q == ST_PWAIT)
    else $error("Program command did not start the sequencer.");

  // Watches the array strobe itself, so a program or an erase that
  // reaches a locked block is caught whichever state issued it.
  chk_prot_block: assert property (
    @(posedge clk_sys) disable iff (rst)
    !(m_we && lockv[blk_of({m_addr, 2'h0})]))
    else $error("Protected block was written.");

  chk_no_suspend: assert property (
    @(posedge clk_sys) disable iff (rst)
    (st_q == ST_EWAIT) |=> (st_q == ST_EWAIT || st_q == ST_EWALK))
    else $error("Erase left its pulse early.");

  chk_busy_status: assert property (
    @(posedge clk_sys) disable iff (rst)
    (rd && st_q != ST_IDLE && !mode_q.interleave) |-> ##2
    (rsp_q.rdata[31:8] == 24'h0 && rsp_q.rdata[TOG_BIT] == $past(tog_q)))
    else $error("Busy read did not return status.");

  chk_secure_read: assert property (
    @(posedge clk_sys) disable iff (rst)
    (rsp_q.valid && !$past(rd_stat_q) && $past(secure_q && prog_mode))
    |-> rsp_q.rdata == 32'h0)
    else $error("Secured array data was read in programmer mode.");

endmodule

// ---- logic/fpe_pkg.sv ----
// Constants, types and helpers shared by the flash controller files.
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
package fpe_pkg;

  // -------------------------------------------------------------------
  // Geometry and timing
  // -------------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned N_BLK = 19;
  localparam int unsigned AW = 19;
  localparam int unsigned WAW = 17;
  localparam int unsigned N_WORDS = 131072;
  localparam int unsigned PROG_TIME_US = 20;
  localparam int unsigned PROG_CYC = PROG_TIME_US * CLK_MHZ;
  localparam int unsigned CHIP_ERASE_S = 30;
  localparam int unsigned CHIP_ERASE_CYC = CHIP_ERASE_S * CLK_MHZ * 1000000;
  localparam int unsigned MB_WIN_US = 50;
  localparam int unsigned MB_WIN_CYC = MB_WIN_US * CLK_MHZ;
  localparam logic [1:0] RD_LAT_FAST = 2'h0;
  localparam logic [1:0] RD_LAT_ILV = 2'h1;

  // -------------------------------------------------------------------
  // Command cycles, halfword addresses and data
  // -------------------------------------------------------------------
  localparam logic [14:0] CMD_A1 = 15'h5555;
  localparam logic [14:0] CMD_A2 = 15'h2aaa;
  localparam logic [15:0] D_UNL1 = 16'h00aa;
  localparam logic [15:0] D_UNL2 = 16'h0055;
  localparam logic [15:0] D_PROG = 16'h00a0;
  localparam logic [15:0] D_SEC = 16'h00a5;
  localparam logic [15:0] D_PROT = 16'h009a;
  localparam logic [15:0] D_ERS = 16'h0080;
  localparam logic [15:0] D_CHIP = 16'h0010;
  localparam logic [15:0] D_BLK = 16'h0030;
  localparam logic [15:0] D_RST = 16'h00f0;
  localparam logic [1:0] OP_PROG = 2'h0;
  localparam logic [1:0] OP_SEC = 2'h1;
  localparam logic [1:0] OP_PROT = 2'h2;

  // -------------------------------------------------------------------
  // Status word bit positions and reset values
  // -------------------------------------------------------------------
  localparam int unsigned POLL_BIT = 7;
  localparam int unsigned TOG_BIT = 6;
  localparam int unsigned FAIL_BIT = 5;
  localparam logic [N_BLK-1:0] PROT_RST = 19'h00000;
  localparam logic [31:0] ERASED = 32'hffffffff;

  typedef struct packed {
    logic valid;
    logic we;
    logic [AW-1:0] addr;
    logic [15:0] wdata;
  } fpe_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] rdata;
  } fpe_rsp_t;

  typedef struct packed {
    logic interleave;
    logic boot_rom;
    logic strap_a;
    logic strap_b;
  } fpe_mode_t;

  localparam fpe_mode_t MODE_RST = 4'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PWAIT = 3'h1,
    ST_PVER = 3'h3,
    ST_ECOL = 3'h2,
    ST_EWAIT = 3'h6,
    ST_EWALK = 3'h7,
    ST_EVER = 3'h5
  } fpe_state_t;

  // Fifteen 32K blocks, then 16K, 8K and two 4K blocks at the top.
  function automatic logic [4:0] blk_of(input logic [AW-1:0] a);
    logic [4:0] b;
    b = {1'b0, a[18:15]};
    if (a[18:15] == 4'hf) begin
      if (!a[14]) b = 5'h0f;
      else if (!a[13]) b = 5'h10;
      else if (!a[12]) b = 5'h11;
      else b = 5'h12;
    end
    return b;
  endfunction

endpackage

// ---- sim/fpe_host_model.sv ----
// Core-side bus master model that issues flash requests.
`timescale 1ns/1ps
module fpe_host_model
  import fpe_pkg::*;
(
  output fpe_req_t req
  , input wire logic clk_sys
);
  initial req = '0;

  // Writes carry one halfword; wider data cannot be expressed here.
  task automatic wr(input logic [AW-1:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    req <= '{valid: 1'b1, we: 1'b1, addr: a, wdata: d};
    @(posedge clk_sys);
    req <= '{valid: 1'b0, we: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // A read stays alone on the bus until its answer is due.
  task automatic rd(input logic [AW-1:0] a);
    @(posedge clk_sys);
    req <= '{valid: 1'b1, we: 1'b0, addr: a, wdata: 16'h0000};
    @(posedge clk_sys);
    req <= '{valid: 1'b0, we: 1'b1, addr: ~a, wdata: 16'hffff};
    repeat (3) @(posedge clk_sys);
  endtask
endmodule

// ---- sim/onchip_flash_program_erase_control_tb_top.sv ----
// Self-checking testbench for the flash program and erase controller.
`timescale 1ns/1ps
module onchip_flash_program_erase_control_tb_top
  import fpe_pkg::*;
;
  typedef struct packed {
    logic [31:0] exp;
    logic [31:0] mask;
    logic tog;
  } fpe_note_t;
  localparam logic [AW-1:0] BA1 = {3'h0, CMD_A1, 1'h0};
  localparam logic [AW-1:0] BA2 = {3'h0, CMD_A2, 1'h0};
  localparam logic [31:0] ALL = 32'hffffffff;
  localparam logic [31:0] NTOG = 32'hffffffbf;
  logic clk_sys, rst, prog_mode, vpp_high;
  logic boot_strap_pin, interleave_strap_pin;
  logic reset_sampled_strap_a, reset_sampled_strap_b;
  fpe_req_t req;
  fpe_rsp_t rsp_q;
  fpe_mode_t mode_q, mode_exp;
  logic busy_q, secure_q, last_tog;
  logic [N_BLK-1:0] prot_q;
  logic [AW-1:0] a;
  logic [15:0] d;
  logic [31:0] w0;
  fpe_note_t notes[$];
  fpe_note_t note;
  int num_errors, check_count, cyc, busy_len;

  fpe_host_model host (.clk_sys(clk_sys), .req(req));
  fpe_flash_ctrl #(.ERASE_CYC(20)) uut (
    .clk_sys(clk_sys), .rst(rst), .req(req), .prog_mode(prog_mode),
    .vpp_high(vpp_high), .boot_strap_pin(boot_strap_pin),
    .interleave_strap_pin(interleave_strap_pin),
    .reset_sampled_strap_a(reset_sampled_strap_a),
    .reset_sampled_strap_b(reset_sampled_strap_b), .rsp_q(rsp_q),
    .busy_q(busy_q), .mode_q(mode_q), .secure_q(secure_q), .prot_q(prot_q)
  );

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // Compare tasks and answer monitor
  // ---------------------------------------------------------------
  task automatic check_rd(input logic [31:0] got, input logic [31:0] exp,
                          input logic [31:0] m);
    check_count++;
    if ((got & m) !== (exp & m)) begin
      num_errors++;
      $display("ERROR %0t read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp,
                           input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s is %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(negedge clk_sys) begin
    if (busy_q === 1'b1) busy_len++;
    if (rsp_q.valid === 1'b1) begin
      if (notes.size() == 0) begin
        num_errors++;
        $display("ERROR %0t answer without request", $time);
      end else begin
        note = notes.pop_front();
        if (note.tog) check_bit(rsp_q.rdata[TOG_BIT], ~last_tog, "tog");
        check_rd(rsp_q.rdata, note.exp, note.mask);
        last_tog = rsp_q.rdata[TOG_BIT];
      end
    end
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      $display("ERROR %0t run did not finish", $time);
      summarize();
    end
  end

  // ---------------------------------------------------------------
  // Stimulus helpers
  // ---------------------------------------------------------------
  task automatic rd(input logic [AW-1:0] ra, input logic [31:0] e,
                    input logic [31:0] m, input logic t);
    notes.push_back('{exp: e, mask: m, tog: t});
    host.rd(ra);
  endtask

  task automatic cmd(input logic [15:0] c);
    host.wr(BA1, D_UNL1);
    host.wr(BA2, D_UNL2);
    host.wr(BA1, c);
  endtask

  // Program one halfword; go says whether the sequence must start.
  task automatic prog(input logic [15:0] c, input logic [AW-1:0] pa,
                      input logic [15:0] v, input logic go);
    cmd(c);
    busy_len = 0;
    host.wr(pa, v);
    @(negedge clk_sys);
    check_bit(busy_q, go, "busy");
    if (go) begin
      rd(pa, {24'h000000, ~v[7], 7'h00}, NTOG, 1'b0);
      rd(pa, {24'h000000, ~v[7], 7'h00}, NTOG, 1'b1);
      while (busy_q === 1'b1 && busy_len < 1100) @(negedge clk_sys);
      check_bit(busy_len >= PROG_CYC && busy_len < 1100, 1'b1, "len");
    end
  endtask

  // Straps change during reset and stay still around its release.
  task automatic reset_chk(input logic il);
    @(posedge clk_sys);
    rst <= 1'b1;
    {boot_strap_pin, reset_sampled_strap_a, reset_sampled_strap_b} <=
      3'($urandom);
    interleave_strap_pin <= il;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    mode_exp = '{interleave: il, boot_rom: ~boot_strap_pin,
                 strap_a: reset_sampled_strap_a,
                 strap_b: reset_sampled_strap_b};
    @(negedge clk_sys);
    check_bit(mode_q === mode_exp, 1'b1, "mode");
    check_bit(|{prot_q, secure_q, busy_q}, 1'b0, "clear");
    @(posedge clk_sys);
    {boot_strap_pin, interleave_strap_pin} <= ~{boot_strap_pin, il};
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check_bit(mode_q === mode_exp, 1'b1, "held");
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    prog_mode = 1'b0;
    vpp_high = 1'b0;
    {boot_strap_pin, interleave_strap_pin} = 2'h0;
    {reset_sampled_strap_a, reset_sampled_strap_b} = 2'h0;
    num_errors = 0;
    check_count = 0;
    cyc = 0;
    last_tog = 1'b0;
    void'($urandom(56572));
    reset_chk(1'b0);
    rd(19'h01234, ERASED, ALL, 1'b0);
    a = 19'h01000 | 19'($urandom & 2);
    d = 16'($urandom);
    w0 = a[1] ? {d, 16'hffff} : {16'hffff, d};
    prog(D_PROG, a, d, 1'b1);
    rd(a, w0, ALL, 1'b0);
    // A reset cycle in mid-command must drop the pending program.
    cmd(D_PROG);
    host.wr(BA1, D_RST);
    host.wr(19'h02000, d);
    @(negedge clk_sys);
    check_bit(busy_q, 1'b0, "abort");
    cmd(D_PROT);
    host.wr(19'h7f000, 16'h0000);
    @(negedge clk_sys);
    check_bit(prot_q === 19'h40000, 1'b1, "prot");
    d = 16'($urandom);
    prog(D_PROG, 19'h7f004, d, 1'b0);
    rd(19'h7f004, ERASED, ALL, 1'b0);
    vpp_high <= 1'b1;
    prog(D_PROG, 19'h7f004, d, 1'b1);
    rd(19'h7f004, {16'hffff, d}, ALL, 1'b0);
    vpp_high <= 1'b0;
    prog(D_SEC, 19'h00100, d, 1'b1);
    check_bit(secure_q, 1'b1, "secure");
    @(posedge clk_sys);
    prog_mode <= 1'b1;
    rd(19'h00100, 32'h00000000, ALL, 1'b0);
    prog_mode <= 1'b0;
    rd(19'h00100, {16'hffff, d}, ALL, 1'b0);
    cmd(D_ERS);
    host.wr(BA1, D_UNL1);
    host.wr(BA2, D_UNL2);
    host.wr(19'h08000, D_BLK);
    @(negedge clk_sys);
    check_bit(busy_q, 1'b1, "erase");
    repeat (2600) @(posedge clk_sys);
    host.wr(BA1, D_RST);
    rd(BA1, 32'h00000000, NTOG, 1'b0);
    rd(BA1, 32'h00000000, NTOG, 1'b1);
    repeat (200) @(posedge clk_sys);
    @(negedge clk_sys);
    check_bit(busy_q, 1'b1, "erase run");
    reset_chk(1'b1);
    rd(a, w0, ALL, 1'b0);
    // Chip erase must start at once and drop the security state.
    prog(D_SEC, 19'h00200, d, 1'b1);
    cmd(D_ERS);
    host.wr(BA1, D_UNL1);
    host.wr(BA2, D_UNL2);
    host.wr(BA1, D_CHIP);
    @(negedge clk_sys);
    check_bit(busy_q & ~secure_q, 1'b1, "chip erase");
    repeat (4) @(posedge clk_sys);
    check_bit(notes.size() == 0, 1'b1, "pending");
    summarize();
  end
endmodule
